// >>> hdl/mode_reg_defs.svh
// Constants for the operating-mode register bank
`ifndef MODE_REG_DEFS_SVH
`define MODE_REG_DEFS_SVH
`define OPMODE_REG_SEL 3'h1
`define DATA_REG_SEL 3'h3
`define OPMODE_RESET 24'h080060
`define OPMODE_WIDTH 24
`define OPMODE_FIXED_ZERO_MASK 24'hFFBFFF
`define COMMS_RW_BIT 6
`define COMMS_RS_HI 5
`define COMMS_RS_LO 3
`define CLKSEL_CRYSTAL 2'h0
`define CLKSEL_EXTCLK 2'h1
`define CLKSEL_INT_TRI 2'h2
`define CLKSEL_INT_OUT 2'h3
`endif

// >>> hdl/mode_reg_pkg.sv
// Types for the operating-mode register bank
package mode_reg_pkg;
    typedef struct packed {
        logic [2:0] op_mode_sel;
        logic status_append_en;
        logic [1:0] clk_src_sel;
        logic avg_sel_hi;
        logic avg_sel_lo;
        logic third_order_filter_sel;
        logic fixed_zero;
        logic parity_check_en;
        logic clk_div;
        logic single_cycle;
        logic notch60_en;
        logic [9:0] rate_word;
    } opmode_s;
    typedef enum logic [1:0] {ST_COMMS, ST_WRITE, ST_READ} serial_e;
endpackage

// >>> hdl/opmode_regbank.sv
// Operating-mode register with its serial access port
//
// Function
// - Register-select code 001 addresses this register, which resets to 0x080060.
// - The register is 24 bits wide and can be both read and written.
// - Serial transfers run from bit 23 down to bit 0 in both directions.
// - Each completed write restarts modulator and filter and sets not-ready.
// - Bits 23 to 21 choose the operating mode and reset to zero.
// - With bit 20 set the status byte follows every data word read.
// - Bits 19 and 18 choose the converter clock source, internal at reset.
// - Fields sit at fixed positions with bit 14 always reading zero.
// - Codes 00 and 01 use external clocking, 10 internal with pin off, 11 internal driven out.
// - With parity enabled the parity flag shows odd ones in the data word.
`timescale 1ns/1ns
`default_nettype none
`include "mode_reg_defs.svh"
module opmode_regbank (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic SCLK,
    input wire logic CS_B,
    input wire logic DIN,
    output logic DOUT,
    output logic DOUT_OE,
    input wire logic [23:0] DATA_WORD,
    input wire logic DATA_VALID,
    input wire logic INT_CLK,
    input wire logic MASTER_CLK_IO_IN,
    output logic MASTER_CLK_IO_OUT,
    output logic MASTER_CLK_IO_OE,
    output logic CONV_CLK,
    output logic FILTER_RESTART,
    output logic [2:0] OP_MODE_SEL,
    output logic STATUS_APPEND_EN,
    output logic [1:0] AVG_SEL,
    output logic THIRD_ORDER_FILTER_SEL,
    output logic CLK_DIV,
    output logic SINGLE_CYCLE,
    output logic NOTCH60_EN,
    output logic [9:0] RATE_WORD,
    output logic [7:0] STATUS_BYTE
);
    // ****************
    // Reset and input sync
    // ****************
    logic rst_s1_reg, rst_b_reg;
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_reg <= 1'b0;
            rst_b_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_b_reg <= rst_s1_reg;
        end
    end
    logic [2:0] sclk_sync_reg, csb_sync_reg, din_sync_reg;
    logic sclk_reg, csb_reg;
    always_ff @(posedge CLOCK or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            sclk_sync_reg <= 3'h7;
            csb_sync_reg <= 3'h7;
            din_sync_reg <= 3'h0;
            sclk_reg <= 1'b1;
            csb_reg <= 1'b1;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], SCLK};
            csb_sync_reg <= {csb_sync_reg[1:0], CS_B};
            din_sync_reg <= {din_sync_reg[1:0], DIN};
            if (sclk_sync_reg[1] == sclk_sync_reg[2]) begin
                sclk_reg <= sclk_sync_reg[2];
            end
            if (csb_sync_reg[1] == csb_sync_reg[2]) begin
                csb_reg <= csb_sync_reg[2];
            end
        end
    end
    logic sclk_prev_reg;
    always_ff @(posedge CLOCK or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            sclk_prev_reg <= 1'b1;
        end else begin
            sclk_prev_reg <= sclk_reg;
        end
    end
    logic rise, fall;
    assign rise = !csb_reg && sclk_reg && !sclk_prev_reg;
    assign fall = !csb_reg && !sclk_reg && sclk_prev_reg;

    // ****************
    // Serial engine
    // ****************
    mode_reg_pkg::serial_e state_reg;
    logic [5:0] bit_cnt_reg;
    logic [31:0] shift_reg;
    logic [23:0] in_shift_reg;
    mode_reg_pkg::opmode_s mode_reg;
    logic write_done;
    logic [7:0] status_reg;
    logic [23:0] data_hold_reg;
    logic [5:0] read_len;
    logic [2:0] rs_in;
    logic [5:0] shift_len_reg;
    assign rs_in = in_shift_reg[`COMMS_RS_HI-1:`COMMS_RS_LO-1];
    assign read_len = (rs_in == `DATA_REG_SEL && mode_reg.status_append_en) ? 6'h20 : 6'h18;
    assign write_done = (state_reg == mode_reg_pkg::ST_WRITE) && rise && bit_cnt_reg == 6'h17;
    always_ff @(posedge CLOCK or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            state_reg <= mode_reg_pkg::ST_COMMS;
            bit_cnt_reg <= 6'h0;
            in_shift_reg <= 24'h0;
        end else if (csb_reg) begin
            state_reg <= mode_reg_pkg::ST_COMMS;
            bit_cnt_reg <= 6'h0;
        end else if (rise) begin
            in_shift_reg <= {in_shift_reg[22:0], din_sync_reg[2]};
            bit_cnt_reg <= bit_cnt_reg + 6'h1;
            case (state_reg)
                mode_reg_pkg::ST_COMMS: begin
                    if (bit_cnt_reg == 6'h7) begin
                        bit_cnt_reg <= 6'h0;
                        if ({in_shift_reg[`COMMS_RS_HI-1:`COMMS_RS_LO-1]} != `OPMODE_REG_SEL
                            && {in_shift_reg[`COMMS_RS_HI-1:`COMMS_RS_LO-1]} != `DATA_REG_SEL) begin
                            state_reg <= mode_reg_pkg::ST_COMMS;
                        end else if (in_shift_reg[`COMMS_RW_BIT-1]) begin
                            state_reg <= mode_reg_pkg::ST_READ;
                        end else if (rs_in == `OPMODE_REG_SEL) begin
                            state_reg <= mode_reg_pkg::ST_WRITE;
                        end
                    end
                end
                mode_reg_pkg::ST_WRITE: begin
                    if (bit_cnt_reg == 6'h17) begin
                        state_reg <= mode_reg_pkg::ST_COMMS;
                        bit_cnt_reg <= 6'h0;
                    end
                end
                mode_reg_pkg::ST_READ: begin
                    if (bit_cnt_reg == shift_len_reg - 6'h1) begin
                        state_reg <= mode_reg_pkg::ST_COMMS;
                        bit_cnt_reg <= 6'h0;
                    end
                end
                default: state_reg <= mode_reg_pkg::ST_COMMS;
            endcase
        end
    end
    always_ff @(posedge CLOCK or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            shift_reg <= 32'h0;
            shift_len_reg <= 6'h18;
        end else if (rise && state_reg == mode_reg_pkg::ST_COMMS && bit_cnt_reg == 6'h7
                     && in_shift_reg[`COMMS_RW_BIT-1]) begin
            shift_len_reg <= read_len;
            if (rs_in == `OPMODE_REG_SEL) begin
                shift_reg <= {mode_reg, 8'h00};
            end else begin
                shift_reg <= {data_hold_reg, status_reg};
            end
        end else if (fall && state_reg == mode_reg_pkg::ST_READ && bit_cnt_reg != 6'h0) begin
            shift_reg <= {shift_reg[30:0], 1'b0};
        end
    end
    always_ff @(posedge CLOCK or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            DOUT <= 1'b0;
            DOUT_OE <= 1'b0;
        end else begin
            DOUT <= shift_reg[31];
            DOUT_OE <= !csb_reg && state_reg == mode_reg_pkg::ST_READ;
        end
    end

    // ****************
    // Register and effects
    // ****************
    always_ff @(posedge CLOCK or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            mode_reg <= `OPMODE_RESET;
        end else if (write_done) begin
            mode_reg <= {in_shift_reg[22:0], din_sync_reg[2]} & `OPMODE_FIXED_ZERO_MASK;
        end
    end
    always_ff @(posedge CLOCK or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            FILTER_RESTART <= 1'b0;
            status_reg <= 8'h80;
            data_hold_reg <= 24'h0;
        end else begin
            FILTER_RESTART <= write_done;
            if (write_done) begin
                status_reg[7] <= 1'b1;
            end else if (DATA_VALID) begin
                status_reg[7] <= 1'b0;
                data_hold_reg <= DATA_WORD;
                status_reg[4] <= mode_reg.parity_check_en && ^DATA_WORD;
            end
        end
    end
    assign OP_MODE_SEL = mode_reg.op_mode_sel;
    assign STATUS_APPEND_EN = mode_reg.status_append_en;
    assign AVG_SEL = {mode_reg.avg_sel_hi, mode_reg.avg_sel_lo};
    assign THIRD_ORDER_FILTER_SEL = mode_reg.third_order_filter_sel;
    assign CLK_DIV = mode_reg.clk_div;
    assign SINGLE_CYCLE = mode_reg.single_cycle;
    assign NOTCH60_EN = mode_reg.notch60_en;
    assign RATE_WORD = mode_reg.rate_word;
    assign STATUS_BYTE = status_reg;
    assign CONV_CLK = mode_reg.clk_src_sel[1] ? INT_CLK : MASTER_CLK_IO_IN;
    assign MASTER_CLK_IO_OUT = INT_CLK;
    assign MASTER_CLK_IO_OE = mode_reg.clk_src_sel == `CLKSEL_INT_OUT;
endmodule // opmode_regbank
`default_nettype wire

// >>> bench/opmode_props.sv
// Checker for the operating-mode register ports
`timescale 1ns/1ns
`default_nettype none
module opmode_props (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic CS_B,
    input wire logic DOUT_OE,
    input wire logic INT_CLK,
    input wire logic MASTER_CLK_IO_OE,
    input wire logic CONV_CLK,
    input wire logic FILTER_RESTART,
    input wire logic [2:0] OP_MODE_SEL,
    input wire logic [9:0] RATE_WORD,
    input wire logic [7:0] STATUS_BYTE
);
    wire logic [12:0] flds = {OP_MODE_SEL, RATE_WORD};
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    sequence s_pulse;
        FILTER_RESTART ##1 !FILTER_RESTART;
    endsequence
    AST_RST: assert property ($rose(RST_B) |-> flds == 13'h060) else $error("reset");
    AST_CHG: assert property (!$stable(flds) |-> FILTER_RESTART) else $error("pulse");
    AST_CS: assert property (!$stable(flds) |-> !CS_B) else $error("commit");
    AST_PLS: assert property ($rose(FILTER_RESTART) |-> s_pulse) else $error("width");
    AST_RDY: assert property (FILTER_RESTART |-> ##[0:1] STATUS_BYTE[7]) else $error("rdy");
    AST_STS: assert property ((STATUS_BYTE & 8'h6F) == 8'h00) else $error("status");
    AST_CLK: assert property (MASTER_CLK_IO_OE |-> CONV_CLK == INT_CLK) else $error("clk");
    AST_OE: assert property ($rose(DOUT_OE) |-> !CS_B) else $error("oe");
endmodule // opmode_props
bind opmode_regbank opmode_props u_props (.CLOCK(CLOCK), .RST_B(RST_B), .CS_B(CS_B),
    .DOUT_OE(DOUT_OE), .INT_CLK(INT_CLK), .MASTER_CLK_IO_OE(MASTER_CLK_IO_OE),
    .CONV_CLK(CONV_CLK), .FILTER_RESTART(FILTER_RESTART), .OP_MODE_SEL(OP_MODE_SEL),
    .RATE_WORD(RATE_WORD), .STATUS_BYTE(STATUS_BYTE));
`default_nettype wire

// >>> bench/host_model.sv
// Host serial master model
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input wire logic CLOCK,
    input wire logic DOUT,
    output logic SCLK,
    output logic CS_B,
    output logic DIN,
    output logic done,
    output logic [31:0] rdata
);
    initial {SCLK, CS_B, DIN, done, rdata} = 36'hC00000000;
    task automatic xfer(input logic [7:0] cm, input logic [31:0] wd, input int n, input int cut);
        logic [39:0] sh;
        sh = {cm, wd};
        @(posedge CLOCK) CS_B <= 1'b0;
        rdata <= 32'h0;
        repeat (4) @(posedge CLOCK);
        for (int i = 0; i < 8 + n && i != cut; i++) begin
            SCLK <= 1'b0;
            DIN <= (cm[6] && i > 7) ? ~DIN : sh[39 - i];
            repeat (8) @(posedge CLOCK);
            SCLK <= 1'b1;
            if (i > 7) rdata <= {rdata[30:0], DOUT};
            repeat (8) @(posedge CLOCK);
        end
        repeat (8) @(posedge CLOCK);
        CS_B <= 1'b1;
        DIN <= ~DIN;
        done <= cm[6] && cut < 0;
        @(posedge CLOCK) done <= 1'b0;
        repeat (8) @(posedge CLOCK);
    endtask
endmodule // host_model
`default_nettype wire

// >>> bench/adc_mode_register_bench.sv
// Testbench for the operating-mode register
`timescale 1ns/1ns
`default_nettype none
`include "mode_reg_defs.svh"
module adc_mode_register_bench;
    logic clk = 1'b0, rst_b = 1'b0, dvalid = 1'b0, intclk = 1'b0, mclk = 1'b0, pvld = 1'b0;
    logic [23:0] dword = 24'h0, v;
    logic [31:0] pobs = 32'h0, want, obs;
    logic [31:0] exq[$];
    int seed = 86, num_errors = 0, n_tests = 0;
    wire logic sclk, cs_b, din, dout, done, oe, ck, sa, tf, cd, sc, ne, mo;
    wire logic [1:0] av;
    wire logic [2:0] om;
    wire logic [9:0] rw;
    wire logic [7:0] sb;
    wire logic [31:0] rdata;
    always #25 clk = ~clk;
    opmode_regbank u_opmode_regbank (.CLOCK(clk), .RST_B(rst_b), .SCLK(sclk), .CS_B(cs_b),
        .DIN(din), .DOUT(dout), .DOUT_OE(), .DATA_WORD(dword), .DATA_VALID(dvalid),
        .INT_CLK(intclk), .MASTER_CLK_IO_IN(mclk), .MASTER_CLK_IO_OUT(mo),
        .MASTER_CLK_IO_OE(oe), .CONV_CLK(ck), .FILTER_RESTART(), .OP_MODE_SEL(om),
        .STATUS_APPEND_EN(sa), .AVG_SEL(av), .THIRD_ORDER_FILTER_SEL(tf), .CLK_DIV(cd),
        .SINGLE_CYCLE(sc), .NOTCH60_EN(ne), .RATE_WORD(rw), .STATUS_BYTE(sb));
    host_model u_host_model (.CLOCK(clk), .DOUT(dout), .SCLK(sclk), .CS_B(cs_b), .DIN(din),
        .done(done), .rdata(rdata));
    always @(posedge clk) begin
        if (done === 1'b1 || pvld === 1'b1) begin
            want = exq.pop_front();
            obs = (done === 1'b1) ? rdata : pobs;
            n_tests++;
            if (obs !== want) begin
                num_errors++;
                $display("Error result expected %h seen %h", want, obs);
            end
        end
    end
    task automatic chk(input logic [31:0] exp, input logic [31:0] seen);
        exq.push_back(exp);
        @(posedge clk) pobs <= seen;
        pvld <= 1'b1;
        @(posedge clk) pvld <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] cm, input logic [23:0] d, input int cut);
        u_host_model.xfer(cm, {d, 8'h00}, 24, cut);
    endtask
    task automatic rd(input logic [31:0] exp, input logic [7:0] cm, input int n);
        exq.push_back(exp);
        u_host_model.xfer(cm, 32'h0, n, -1);
    endtask
    task automatic test_done();
        $display("Checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        rd({8'h00, `OPMODE_RESET}, 8'h48, 24);
        for (int k = 0; k < 4; k++) begin
            v = 24'($random(seed));
            v[19:18] = k[1:0];
            intclk <= k[0];
            mclk <= ~k[0];
            dvalid <= 1'b1;
            @(posedge clk) dvalid <= 1'b0;
            wr(8'h08, v, -1);
            chk(32'h1, sb[7]);
            rd({8'h00, v & `OPMODE_FIXED_ZERO_MASK}, 8'h48, 24);
            chk({v[23:20], v[17:15], v[12:0]}, {om, sa, av, tf, cd, sc, ne, rw});
            chk({k == 3, k[1] ? intclk : mclk, intclk}, {oe, ck, mo});
        end
        wr(8'h08, ~v, 20);
        wr(8'h10, ~v, -1);
        wr(8'h18, ~v, -1);
        rd({8'h00, v & `OPMODE_FIXED_ZERO_MASK}, 8'h48, 24);
        v[20] = 1'b1;
        v[13] = 1'b1;
        wr(8'h08, v, -1);
        dword <= ~v;
        dvalid <= 1'b1;
        @(posedge clk) dvalid <= 1'b0;
        repeat (2) @(posedge clk);
        chk(^dword, sb[4]);
        rd({dword, 3'h0, ^dword, 4'h0}, 8'h58, 32);
        test_done();
    end
endmodule // adc_mode_register_bench
`default_nettype wire
